/* hdl/ric_params.svh */
/*
  Offsets, field positions, reset values and timing figures for the
  remote interface configuration block.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef RIC_PARAMS_SVH
`define RIC_PARAMS_SVH

// Clock
`define RIC_CLK_HZ          250000000

// Register byte offsets
`define RIC_OFS_GPIB        8'h00
`define RIC_OFS_SER         8'h04
`define RIC_OFS_NET         8'h08
`define RIC_OFS_IP          8'h0c
`define RIC_OFS_MASK        8'h10
`define RIC_OFS_GW          8'h14
`define RIC_OFS_IFRST       8'h18
`define RIC_OFS_STAT        8'h1c
`define RIC_OFS_ERR         8'h20
`define RIC_OFS_NETIP       8'h24

// Field positions
`define RIC_GPIB_EN_BIT     0
`define RIC_GPIB_ADDR_LSB   1
`define RIC_SER_EN_BIT      0
`define RIC_SER_BAUD_LSB    1
`define RIC_NET_TCP_BIT     0
`define RIC_NET_DHCP_BIT    1
`define RIC_NET_AUTO_BIT    2
`define RIC_NET_STATIC_BIT  3
`define RIC_NET_SOCK_BIT    4
`define RIC_NET_TELNET_BIT  5
`define RIC_NET_VXI_BIT     6
`define RIC_NET_SPEED_LSB   7
`define RIC_IF_GPIB         0
`define RIC_IF_SER          1
`define RIC_IF_NET          2

// Reset values and limits
`define RIC_GPIB_RST        6'h1f
`define RIC_GPIB_ADDR_MAX   5'h1e
`define RIC_SER_RST         4'h3
`define RIC_BAUD_CODE_MAX   3'h5
`define RIC_NET_RST         9'h0ff
`define RIC_ADDR_RST        32'h0000_0000

// Fixed protocol figures
`define RIC_SER_DATA_BITS   4'h8
`define RIC_SER_STOP_BITS   2'h1
`define RIC_SOCK_PORT       16'h13a1
`define RIC_TELNET_PORT     16'h13a0
`define RIC_LINKLOCAL_PFX   16'ha9fe

// Baud rates by code
`define RIC_BAUD_0          4800
`define RIC_BAUD_1          9600
`define RIC_BAUD_2          19200
`define RIC_BAUD_3          38400
`define RIC_BAUD_4          57600
`define RIC_BAUD_5          115200

// Menu lengths
`define RIC_GPIB_ITEMS      4'h3
`define RIC_SER_ITEMS       4'h3
`define RIC_NET_ITEMS       4'hc

// Activity flash, in milliseconds
`define RIC_ACT_FLASH_MS    20
`define RIC_ACT_CYCLES      (`RIC_ACT_FLASH_MS * (`RIC_CLK_HZ / 1000))

`endif

/* hdl/ric_pkg.sv */
/*
  Types for the remote interface configuration block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ric_pkg;

   typedef enum logic [1:0] {
      RIC_MENU_IDLE = 2'b00,
      RIC_MENU_GPIB = 2'b01,
      RIC_MENU_SER  = 2'b11,
      RIC_MENU_NET  = 2'b10
   } ric_menu_t;

   typedef enum logic [1:0] {
      RIC_NET_NONE   = 2'b00,
      RIC_NET_DHCP   = 2'b01,
      RIC_NET_AUTO   = 2'b11,
      RIC_NET_STATIC = 2'b10
   } ric_netmode_t;

   typedef enum logic [1:0] {
      RIC_SPEED_10   = 2'b00,
      RIC_SPEED_100  = 2'b01,
      RIC_SPEED_AUTO = 2'b10
   } ric_speed_t;

endpackage

/* hdl/ric_top.sv */
/*
  Remote interface configuration: APB register slave, pending/active
  settings for GPIB, serial and network ports, menu stepping, and the
  lock, activity and error indicators.
  Assumes an APB master on pclk, front-panel keys and the RTS pin as
  asynchronous pins, and parser/stack events as pclk-domain pulses.
*/
// The register offsets and the APB slave port were left to the implementer.
// Overview of operation
// - All interfaces enabled at reset, individually disableable
// - Edits stay pending until interface reset
// - Reset choice defaults no, yes applies settings
// - Repeated interface key steps to next parameter
// - Serial frame 8 data, 1 stop, no parity
// - RTS/CTS handshake gates both directions
// - Only baud 4800 to 115200 is configurable
// - Baud defaults to 9600
// - Serial port behaves as DCE
// - One master enable for all TCP/IP paths
// - Address source priority DHCP, link-local, manual
// - Link-local 169.254.x.x only after DHCP fails
// - Manual settings fallback, addresses default zero
// - Raw socket port 5025 own enable
// - Telnet port 5024 own enable
// - Link speed 10/100/auto, default 100
// - Lock indicator lit, panel blocked in lockout
// - Local key ends remote lockout
// - Activity pulse per character on any port
// - Error indicator on failed remote command
// - Error view: count first, then each error
`include "ric_params.svh"

module ric_top #(
   parameter int ACT_CYCLES = `RIC_ACT_CYCLES
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 key_shift_pin,
   input  wire logic                 key_gpib_pin,
   input  wire logic                 key_serial_pin,
   input  wire logic                 key_net_pin,
   input  wire logic                 key_local_pin,
   input  wire logic                 key_status_pin,
   input  wire logic                 ser_rts_pin,
   input  wire logic                 ser_rx_room,
   input  wire logic                 remote_lock_req,
   input  wire logic                 char_event,
   input  wire logic                 cmd_error,
   input  wire logic                 dhcp_ok,
   input  wire logic                 autoip_ok,
   input  wire logic [15:0]          autoip_host,
   output logic                      gpib_enable,
   output logic      [4:0]           gpib_address,
   output logic                      ser_enable,
   output logic      [15:0]          ser_baud_div,
   output logic                      ser_cts_pin,
   output logic                      ser_tx_allow,
   output logic                      net_sock_enable,
   output logic                      net_telnet_enable,
   output logic                      net_vxi_enable,
   output ric_pkg::ric_speed_t       eth_speed,
   output ric_pkg::ric_netmode_t     net_mode,
   output logic      [31:0]          net_ip,
   output logic      [31:0]          net_mask,
   output logic      [31:0]          net_gw,
   output logic      [2:0]           if_restart,
   output logic                      remote_lock_indicator,
   output logic                      link_activity_indicator,
   output logic                      error_indicator,
   output ric_pkg::ric_menu_t        menu_iface,
   output logic      [3:0]           menu_item,
   output logic      [7:0]           err_view_idx
);
   import ric_pkg::*;

   localparam int ACT_W = $clog2(ACT_CYCLES + 1);

   logic [5:0]   pend_gpib_q, act_gpib_q;
   logic [3:0]   pend_ser_q,  act_ser_q;
   logic [8:0]   pend_net_q,  act_net_q;
   logic [31:0]  pend_ip_q,   act_ip_q;
   logic [31:0]  pend_mask_q, act_mask_q;
   logic [31:0]  pend_gw_q,   act_gw_q;
   logic [2:0]   if_rst_q;
   logic [7:0]   err_cnt_q;
   logic [ACT_W-1:0] act_cnt_q;
   logic         shift_armed_q;
   logic [6:0]   sync1_q, sync2_q, sync3_q;
   logic [6:0]   key_rise;
   logic         wr_en, rd_en;
   logic         addr_ok;
   logic [31:0]  rd_data;
   ric_netmode_t mode_d;

   // Pins: two flops, then a third stage purely for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 7'h00;
         sync2_q <= 7'h00;
         sync3_q <= 7'h00;
      end else begin
         sync1_q <= {ser_rts_pin, key_status_pin, key_local_pin, key_net_pin,
                     key_serial_pin, key_gpib_pin, key_shift_pin};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end
   assign key_rise = sync2_q & ~sync3_q;

   // APB: one wait state so read data comes straight from a flop
   assign wr_en = psel & penable & pready & pwrite;
   assign rd_en = psel & penable & ~pready & ~pwrite;

   always_comb begin
      addr_ok = 1'b1;
      rd_data = 32'h0000_0000;
      unique case (paddr)
         `RIC_OFS_GPIB:  rd_data = {26'h0, pend_gpib_q};
         `RIC_OFS_SER:   rd_data = {`RIC_SER_STOP_BITS, `RIC_SER_DATA_BITS,
                                    22'h0, pend_ser_q};
         `RIC_OFS_NET:   rd_data = {7'(`RIC_SOCK_PORT), `RIC_TELNET_PORT,
                                    pend_net_q};
         `RIC_OFS_IP:    rd_data = pend_ip_q;
         `RIC_OFS_MASK:  rd_data = pend_mask_q;
         `RIC_OFS_GW:    rd_data = pend_gw_q;
         `RIC_OFS_IFRST: rd_data = 32'h0000_0000;
         `RIC_OFS_STAT:  rd_data = {11'h0, menu_item, menu_iface, net_mode,
                                    error_indicator, remote_lock_indicator,
                                    act_net_q, act_ser_q[0], act_gpib_q[0]};
         `RIC_OFS_ERR:   rd_data = {16'h0, err_view_idx, err_cnt_q};
         `RIC_OFS_NETIP: rd_data = net_ip;
         default:        addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~addr_ok;
         if (rd_en)
            prdata <= addr_ok ? rd_data : 32'h0000_0000;
      end
   end

   // Pending copies: software edits land here only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_gpib_q <= `RIC_GPIB_RST;
         pend_ser_q  <= `RIC_SER_RST;
         pend_net_q  <= `RIC_NET_RST;
         pend_ip_q   <= `RIC_ADDR_RST;
         pend_mask_q <= `RIC_ADDR_RST;
         pend_gw_q   <= `RIC_ADDR_RST;
      end else if (wr_en) begin
         unique case (paddr)
            `RIC_OFS_GPIB:
               // Out-of-range address keeps the old one
               if (pwdata[5:1] <= `RIC_GPIB_ADDR_MAX)
                  pend_gpib_q <= pwdata[5:0];
            `RIC_OFS_SER:
               if (pwdata[3:1] <= `RIC_BAUD_CODE_MAX)
                  pend_ser_q <= pwdata[3:0];
            `RIC_OFS_NET:
               if (pwdata[8:7] != 2'b11)
                  pend_net_q <= pwdata[8:0];
            `RIC_OFS_IP:   pend_ip_q   <= pwdata;
            `RIC_OFS_MASK: pend_mask_q <= pwdata;
            `RIC_OFS_GW:   pend_gw_q   <= pwdata;
            default: ;
         endcase
      end
   end

   // Reset-interface choice: reads back as no, a written yes is one pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         if_rst_q <= 3'h0;
      else if (wr_en && paddr == `RIC_OFS_IFRST)
         if_rst_q <= pwdata[2:0];
      else
         if_rst_q <= 3'h0;
   end

   // Active copies load from pending on interface reset; power-up gives defaults
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_gpib_q <= `RIC_GPIB_RST;
         act_ser_q  <= `RIC_SER_RST;
         act_net_q  <= `RIC_NET_RST;
         act_ip_q   <= `RIC_ADDR_RST;
         act_mask_q <= `RIC_ADDR_RST;
         act_gw_q   <= `RIC_ADDR_RST;
      end else begin
         if (if_rst_q[`RIC_IF_GPIB])
            act_gpib_q <= pend_gpib_q;
         if (if_rst_q[`RIC_IF_SER])
            act_ser_q <= pend_ser_q;
         if (if_rst_q[`RIC_IF_NET]) begin
            act_net_q  <= pend_net_q;
            act_ip_q   <= pend_ip_q;
            act_mask_q <= pend_mask_q;
            act_gw_q   <= pend_gw_q;
         end
      end
   end

   // Interface outputs from active copies
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gpib_enable       <= 1'b0;
         gpib_address      <= 5'h00;
         ser_enable        <= 1'b0;
         ser_baud_div      <= 16'h0000;
         net_sock_enable   <= 1'b0;
         net_telnet_enable <= 1'b0;
         net_vxi_enable    <= 1'b0;
         eth_speed         <= RIC_SPEED_100;
         if_restart        <= 3'h0;
      end else begin
         gpib_enable  <= act_gpib_q[`RIC_GPIB_EN_BIT];
         gpib_address <= act_gpib_q[`RIC_GPIB_ADDR_LSB +: 5];
         ser_enable   <= act_ser_q[`RIC_SER_EN_BIT];
         unique case (act_ser_q[`RIC_SER_BAUD_LSB +: 3])
            3'h0:    ser_baud_div <= 16'(`RIC_CLK_HZ / `RIC_BAUD_0);
            3'h1:    ser_baud_div <= 16'(`RIC_CLK_HZ / `RIC_BAUD_1);
            3'h2:    ser_baud_div <= 16'(`RIC_CLK_HZ / `RIC_BAUD_2);
            3'h3:    ser_baud_div <= 16'(`RIC_CLK_HZ / `RIC_BAUD_3);
            3'h4:    ser_baud_div <= 16'(`RIC_CLK_HZ / `RIC_BAUD_4);
            3'h5:    ser_baud_div <= 16'(`RIC_CLK_HZ / `RIC_BAUD_5);
            default: ser_baud_div <= 16'(`RIC_CLK_HZ / `RIC_BAUD_1);
         endcase
         net_sock_enable   <= act_net_q[`RIC_NET_TCP_BIT]
                              & act_net_q[`RIC_NET_SOCK_BIT];
         net_telnet_enable <= act_net_q[`RIC_NET_TCP_BIT]
                              & act_net_q[`RIC_NET_TELNET_BIT];
         net_vxi_enable    <= act_net_q[`RIC_NET_TCP_BIT]
                              & act_net_q[`RIC_NET_VXI_BIT];
         eth_speed <= ric_speed_t'(act_net_q[`RIC_NET_SPEED_LSB +: 2]);
         if_restart <= if_rst_q;
      end
   end

   // DCE side: we drive CTS, the terminal drives RTS
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ser_cts_pin  <= 1'b0;
         ser_tx_allow <= 1'b0;
      end else begin
         ser_cts_pin  <= act_ser_q[`RIC_SER_EN_BIT] & ser_rx_room;
         ser_tx_allow <= act_ser_q[`RIC_SER_EN_BIT] & sync2_q[6];
      end
   end

   // Address source by priority; link-local only if DHCP gave nothing
   always_comb begin
      mode_d = RIC_NET_NONE;
      if (act_net_q[`RIC_NET_TCP_BIT]) begin
         if (act_net_q[`RIC_NET_DHCP_BIT] && dhcp_ok)
            mode_d = RIC_NET_DHCP;
         else if (act_net_q[`RIC_NET_AUTO_BIT] && autoip_ok)
            mode_d = RIC_NET_AUTO;
         else if (act_net_q[`RIC_NET_STATIC_BIT])
            mode_d = RIC_NET_STATIC;
      end
   end

   // DHCP lease contents come from the stack; only link-local and manual here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         net_mode <= RIC_NET_NONE;
         net_ip   <= `RIC_ADDR_RST;
         net_mask <= `RIC_ADDR_RST;
         net_gw   <= `RIC_ADDR_RST;
      end else begin
         net_mode <= mode_d;
         unique case (mode_d)
            RIC_NET_AUTO: begin
               net_ip   <= {`RIC_LINKLOCAL_PFX, autoip_host};
               net_mask <= 32'hffff_0000;
               net_gw   <= `RIC_ADDR_RST;
            end
            RIC_NET_STATIC: begin
               net_ip   <= act_ip_q;
               net_mask <= act_mask_q;
               net_gw   <= act_gw_q;
            end
            default: begin
               net_ip   <= `RIC_ADDR_RST;
               net_mask <= `RIC_ADDR_RST;
               net_gw   <= `RIC_ADDR_RST;
            end
         endcase
      end
   end

   // Remote lockout; a request in the same cycle as local wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         remote_lock_indicator <= 1'b0;
      else if (remote_lock_req)
         remote_lock_indicator <= 1'b1;
      else if (key_rise[4])
         remote_lock_indicator <= 1'b0;
   end

   // Menu stepping; panel keys ignored in lockout
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_armed_q <= 1'b0;
         menu_iface    <= RIC_MENU_IDLE;
         menu_item     <= 4'h0;
      end else if (remote_lock_indicator) begin
         shift_armed_q <= 1'b0;
         menu_iface    <= RIC_MENU_IDLE;
         menu_item     <= 4'h0;
      end else if (key_rise[0]) begin
         shift_armed_q <= 1'b1;
      end else if (|key_rise[3:1]) begin
         shift_armed_q <= 1'b0;
         if (shift_armed_q) begin
            menu_item <= 4'h0;
            if (key_rise[1])
               menu_iface <= RIC_MENU_GPIB;
            else if (key_rise[2])
               menu_iface <= RIC_MENU_SER;
            else
               menu_iface <= RIC_MENU_NET;
         end else begin
            unique case (menu_iface)
               RIC_MENU_GPIB:
                  if (key_rise[1])
                     menu_item <= (menu_item == `RIC_GPIB_ITEMS - 4'h1) ? 4'h0
                                  : menu_item + 4'h1;
               RIC_MENU_SER:
                  if (key_rise[2])
                     menu_item <= (menu_item == `RIC_SER_ITEMS - 4'h1) ? 4'h0
                                  : menu_item + 4'h1;
               RIC_MENU_NET:
                  if (key_rise[3])
                     menu_item <= (menu_item == `RIC_NET_ITEMS - 4'h1) ? 4'h0
                                  : menu_item + 4'h1;
               RIC_MENU_IDLE: ;
            endcase
         end
      end
   end

   // Activity flash: any character restarts the stretch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_cnt_q               <= '0;
         link_activity_indicator <= 1'b0;
      end else begin
         if (char_event)
            act_cnt_q <= ACT_W'(ACT_CYCLES);
         else if (act_cnt_q != '0)
            act_cnt_q <= act_cnt_q - ACT_W'(1);
         link_activity_indicator <= char_event | (act_cnt_q > ACT_W'(1));
      end
   end

   // Error light and count; an error in the clearing cycle is kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         error_indicator <= 1'b0;
         err_cnt_q       <= 8'h00;
      end else begin
         if (cmd_error)
            error_indicator <= 1'b1;
         else if (wr_en && paddr == `RIC_OFS_ERR && pwdata[0])
            error_indicator <= 1'b0;
         if (cmd_error && err_cnt_q != 8'hff)
            err_cnt_q <= err_cnt_q + 8'h01;
         else if (!cmd_error && wr_en && paddr == `RIC_OFS_ERR && pwdata[1])
            err_cnt_q <= 8'h00;
      end
   end

   // Status key: index 0 shows the count, then each logged error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         err_view_idx <= 8'h00;
      else if (key_rise[5] && !remote_lock_indicator)
         err_view_idx <= (err_view_idx >= err_cnt_q) ? 8'h00
                         : err_view_idx + 8'h01;
   end

endmodule

/* tb/ric_assertions.sv */
/*
  Port checker for ric_top, bound to every instance.
  Assumes one pclk domain and the ACT_CYCLES of the bound instance.
*/
module ric_assertions
   import ric_pkg::*;
#(
   parameter int ACT_CYCLES = 8
) (
   input wire logic         pclk,
   input wire logic         presetn,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic         pready,
   input wire logic         pslverr,
   input wire logic         char_event,
   input wire logic         cmd_error,
   input wire logic         remote_lock_req,
   input wire logic         ser_rx_room,
   input wire logic         ser_cts_pin,
   input wire logic [4:0]   gpib_address,
   input wire ric_speed_t   eth_speed,
   input wire ric_netmode_t net_mode,
   input wire logic [31:0]  net_ip,
   input wire logic [2:0]   if_restart,
   input wire logic         remote_lock_indicator,
   input wire logic         link_activity_indicator,
   input wire logic         error_indicator
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   int act_cnt_q;
   // Expected flash length, retriggered by every character
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) act_cnt_q <= 0;
      else if (char_event) act_cnt_q <= ACT_CYCLES;
      else if (act_cnt_q != 0) act_cnt_q <= act_cnt_q - 1;
   end
   AST_ACT_STRETCH: assert property (link_activity_indicator == (act_cnt_q != 0))
      else $error("activity flash length wrong");
   AST_ERR_SET: assert property (cmd_error |=> error_indicator)
      else $error("error light missed a failed command");
   AST_LOCK_SET: assert property (remote_lock_req |=> remote_lock_indicator)
      else $error("lock light missed a lock request");
   AST_CTS_ROOM: assert property (ser_cts_pin |-> $past(ser_rx_room))
      else $error("clear to send without room");
   AST_GPIB_RANGE: assert property (gpib_address <= 5'h1e)
      else $error("bus address above 30");
   AST_SPEED_CODE: assert property (eth_speed != 2'h3)
      else $error("illegal link speed");
   AST_LINKLOCAL: assert property (net_mode == RIC_NET_AUTO |-> net_ip[31:16] == 16'ha9fe)
      else $error("link-local address outside its range");
   AST_RESTART_PULSE: assert property (if_restart != 3'h0 |=> if_restart == 3'h0)
      else $error("restart pulse longer than one cycle");
   AST_APB_READY: assert property (pready |-> psel && penable ##1 !pready)
      else $error("ready outside access phase");
   AST_APB_ERR: assert property (pslverr |-> pready)
      else $error("slave error without ready");
   CVR_ACT: cover property (char_event);
   CVR_UNLOCK: cover property ($fell(remote_lock_indicator));
   CVR_AUTO: cover property (net_mode == RIC_NET_AUTO);
endmodule

bind ric_top ric_assertions #(.ACT_CYCLES(ACT_CYCLES)) u_ric_assertions (.pclk, .presetn,
   .psel, .penable, .pready, .pslverr, .char_event, .cmd_error, .remote_lock_req,
   .ser_rx_room, .ser_cts_pin, .gpib_address, .eth_speed, .net_mode, .net_ip, .if_restart,
   .remote_lock_indicator, .link_activity_indicator, .error_indicator);

/* tb/ric_host_model.sv */
/*
  Host on the serial port: raises RTS when ready and sends one
  character per request, only while the device grants CTS.
  Assumes pclk and presetn of the device.
*/
module ric_host_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic rts_ready,
   input  wire logic send_req,
   input  wire logic ser_cts_pin,
   output logic      ser_rts_pin,
   output logic      char_event
);
   timeunit 1ns;
   timeprecision 100ps;
   logic pend_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q      <= 1'b0;
         char_event  <= 1'b0;
         ser_rts_pin <= 1'b0;
      end else begin
         ser_rts_pin <= rts_ready;
         // One pulse stands for a whole 8N1 frame
         char_event  <= pend_q && ser_cts_pin;
         pend_q      <= send_req || (pend_q && !ser_cts_pin);
      end
   end
endmodule

/* tb/ric_top_bench.sv */
/*
  Directed bench for ric_top over APB, panel keys and a serial host.
  Assumes ACT_CYCLES of 8 and a 250 MHz pclk.
*/
module ric_top_bench;
   import ric_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HZ = 250000000;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdat, net_ip, net_mask, net_gw;
   logic pready, pslverr, rerr, ser_rx_room = 0, remote_lock_req = 0, cmd_error = 0;
   logic dhcp_ok = 0, autoip_ok = 0, rts_ready = 1, send_req = 0, ser_rts_pin, char_event;
   logic [15:0] autoip_host = 16'h1234, ser_baud_div;
   logic [5:0] key = 0;
   logic [4:0] gpib_address;
   logic [7:0] err_view_idx;
   logic [3:0] menu_item;
   logic gpib_enable, ser_enable, ser_cts_pin, ser_tx_allow, net_sock_enable, net_telnet_enable;
   logic remote_lock_indicator, link_activity_indicator, error_indicator, net_vxi_enable;
   ric_speed_t eth_speed;
   ric_netmode_t net_mode;
   ric_menu_t menu_iface;
   int n_fail = 0, total_checks = 0, cyc = 0;
   int rate[6] = '{4800, 9600, 19200, 38400, 57600, 115200};

   always #2 pclk = ~pclk;

   ric_top #(.ACT_CYCLES(8)) u_ric_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .key_shift_pin(key[0]), .key_gpib_pin(key[1]),
      .key_serial_pin(key[2]), .key_net_pin(key[3]), .key_local_pin(key[4]),
      .key_status_pin(key[5]), .ser_rts_pin, .ser_rx_room, .remote_lock_req, .char_event,
      .cmd_error, .dhcp_ok, .autoip_ok, .autoip_host, .gpib_enable, .gpib_address,
      .ser_enable, .ser_baud_div, .ser_cts_pin, .ser_tx_allow, .net_sock_enable,
      .net_telnet_enable, .net_vxi_enable, .eth_speed, .net_mode, .net_ip, .net_mask,
      .net_gw, .if_restart(), .remote_lock_indicator, .link_activity_indicator,
      .error_indicator, .menu_iface, .menu_item, .err_view_idx);

   ric_host_model u_ric_host_model (.pclk, .presetn, .rts_ready, .send_req, .ser_cts_pin,
      .ser_rts_pin, .char_event);

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         $display("FAIL %0t timeout", $time);
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Held until pready is sampled; one idle edge keeps drivers single per step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 0;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      apb(0, a, 0);
      chk(rdat & m, exp);
   endtask

   task automatic apply(input int i);
      apb(1, 8'h18, 32'h1 << i);
      repeat (4) @(posedge pclk);
   endtask

   task automatic press(input int i);
      key[i] <= 1;
      repeat (4) @(posedge pclk);
      key[i] <= 0;
      repeat (4) @(posedge pclk);
   endtask

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      repeat (2) @(posedge pclk);
      chk(gpib_enable & ser_enable & net_vxi_enable, 1);
      chk(gpib_address, 15);
      chk(ser_baud_div, HZ / 9600);
      chk(eth_speed, RIC_SPEED_100);
      chk(net_sock_enable & net_telnet_enable, 1);
      rdc(8'h00, 32'h1f, 32'h3f);
      rdc(8'h04, 32'h6000_0003, 32'hfc00_000f);
      rdc(8'h08, 32'h4227_40ff, 32'hffff_ffff);
      for (int a = 8'h0c; a <= 8'h14; a += 4) rdc(a[7:0], 0, 32'hffff_ffff);
      apb(0, 8'h40, 0);
      chk({rerr, |rdat}, 2'b10);
      $display("defaults done");
      apb(1, 8'h00, 32'h3d);
      chk(gpib_address, 15);
      apply(0);
      chk(gpib_address, 30);
      apb(1, 8'h00, 32'h3f);
      rdc(8'h00, 32'h3d, 32'h3f);
      apb(1, 8'h00, 32'h3c);
      apply(0);
      chk({gpib_enable, ser_enable}, 2'b01);
      for (int i = 0; i < 6; i++) begin
         apb(1, 8'h04, (i << 1) | 1);
         apply(1);
         chk(ser_baud_div, HZ / rate[i]);
      end
      apb(1, 8'h04, 32'hd);
      rdc(8'h04, 32'hb, 32'hf);
      apb(1, 8'h04, 32'h2);
      apply(1);
      chk(ser_enable, 0);
      apb(1, 8'h04, 32'h3);
      apply(1);
      $display("pending settings done");
      press(0);
      press(2);
      chk({menu_iface, menu_item}, {RIC_MENU_SER, 4'h0});
      for (int j = 1; j < 4; j++) begin
         press(2);
         chk(menu_item, j % 3);
      end
      remote_lock_req <= 1;
      @(posedge pclk);
      remote_lock_req <= 0;
      @(posedge pclk);
      chk(remote_lock_indicator, 1);
      press(0);
      press(1);
      chk(menu_iface, RIC_MENU_IDLE);
      press(4);
      chk(remote_lock_indicator, 0);
      $display("menu and lock done");
      send_req <= 1;
      @(posedge pclk);
      send_req <= 0;
      repeat (10) @(posedge pclk);
      chk({link_activity_indicator, ser_tx_allow}, 2'b01);
      ser_rx_room <= 1;
      repeat (4) @(posedge pclk);
      chk(link_activity_indicator, 1);
      repeat (10) @(posedge pclk);
      chk(link_activity_indicator, 0);
      autoip_ok <= 1;
      repeat (6) @(posedge pclk);
      chk({net_mode, net_mask[31:2]}, {RIC_NET_AUTO, 30'h3fff_c000});
      chk(net_ip, {16'ha9fe, autoip_host});
      dhcp_ok <= 1;
      repeat (6) @(posedge pclk);
      chk(net_mode, RIC_NET_DHCP);
      dhcp_ok <= 0;
      apb(1, 8'h0c, 32'h0a00_0005);
      apb(1, 8'h08, 32'h0fb);
      apply(2);
      chk({net_mode, net_gw[29:0]}, {RIC_NET_STATIC, 30'h0});
      chk(net_ip, 32'h0a00_0005);
      apb(1, 8'h08, 32'h0fe);
      apply(2);
      chk({net_sock_enable, net_telnet_enable, net_vxi_enable}, 0);
      for (int s = 0; s < 3; s++) begin
         apb(1, 8'h08, (s << 7) | 32'h7f);
         apply(2);
         chk(eth_speed, s);
      end
      $display("serial and network done");
      cmd_error <= 1;
      repeat (2) @(posedge pclk);
      cmd_error <= 0;
      chk(error_indicator, 1);
      rdc(8'h20, 32'h2, 32'hff);
      for (int p = 1; p < 4; p++) begin
         press(5);
         chk(err_view_idx, p % 3);
      end
      apb(1, 8'h20, 32'h1);
      @(posedge pclk);
      chk(error_indicator, 0);
      $display("errors done");
      close_out();
   end
endmodule
